// ===== hw/uart_channel_interrupt_logic.sv
// channel interrupt mask, source priority and line status logic
// Summary of operation
// - fifo mode: receive data event while fill at or above trigger
// - data-ready flag set on char into fifo, cleared when fifo empty
// - fifos on and low mask bits clear gives polled operation
// - line bit1 overrun, bits2-4 head byte errors, bit7 any fifo error
// - line bit5 holding empty, bit6 fifo and shift register empty
// - mask bit0 raises receive data on char present or trigger
// - mask bit1 raises transmit ready, also at once if already empty
// - mask bit2 raises line interrupt on error bits 1 to 4
// - mask bit3 raises modem interrupt on any change bit
// - mask bits 4-7 writable and read only with enhanced enable
// - mask bit4 permits automatic sleep, default off
// - mask bit5 raises interrupt on pause or special character
// - mask bit6 raises interrupt on rts low-to-high
// - mask bit7 raises interrupt on cts low-to-high
// - receive timeout after four characters plus twelve bit times
// - transmit ready from trigger or empty, whole tx in half-duplex
// - source register shows only highest pending source
// - all mask bits reset to zero
// - source codes by priority one to seven, 000001 none
// - clearing by line, holding, source and modem reads or writes
// - pause clears on source read or resume, special on next char
`timescale 1ns/1ns
module uart_channel_interrupt_logic (
   input wire logic MCLK_I,
   input wire logic SYS_RST_I,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [4:2] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   input wire uart_irq_pkg::engine_s ENG_I,
   input wire logic BIT_TICK_I,
   input wire logic [7:0] FEATURE_CTRL_I,
   output logic IRQ_O,
   output logic SLEEP_EN_O,
   output logic RX_READ_O,
   output logic TX_WRITE_O,
   output logic [7:0] TX_DATA_O
);
   logic [7:0] mask_ff;
   logic [7:0] efr_ff;
   logic [7:0] fcr_ff;
   logic ack_ff;
   logic [31:0] rdat_ff;
   logic irq_ff;
   logic sleep_ff;
   logic rxrd_ff;
   logic txwr_ff;
   logic [7:0] txd_ff;
   logic dready_ff;
   logic [3:0] line_err_ff;
   logic tx_pend_ff;
   logic tx_src_ff;
   logic xoff_ff;
   logic special_ff;
   logic flow_ff;
   logic tmo_q;

   // bus decode, ack pulses one cycle per request
   wire req = WB_CYC_I && WB_STB_I && !ack_ff;
   wire wr = req && WB_WE_I && WB_SEL_I[0];
   wire rd = req && !WB_WE_I;
   wire hit_rx = WB_ADR_I == uart_irq_pkg::ADR_RX_TX;
   wire hit_mask = WB_ADR_I == uart_irq_pkg::ADR_MASK;
   wire hit_src = WB_ADR_I == uart_irq_pkg::ADR_SOURCE;
   wire hit_fcr = WB_ADR_I == uart_irq_pkg::ADR_FCR;
   wire hit_line = WB_ADR_I == uart_irq_pkg::ADR_LINE;
   wire hit_modem = WB_ADR_I == uart_irq_pkg::ADR_MODEM;
   wire hit_efr = WB_ADR_I == uart_irq_pkg::ADR_EFR;
   wire rd_rx = rd && hit_rx;
   wire rd_src = rd && hit_src;
   wire rd_line = rd && hit_line;
   wire rd_modem = rd && hit_modem;
   wire wr_tx = wr && hit_rx;
   wire wr_mask = wr && hit_mask;

   // enhanced gating of upper mask bits
   wire enh = efr_ff[uart_irq_pkg::EFR_ENH_BIT];
   wire [7:0] mask_vis = enh ? mask_ff :
      (mask_ff & uart_irq_pkg::LOW_MASK);
   wire fifo_on = fcr_ff[uart_irq_pkg::FCR_EN_BIT];
   wire rs485 = FEATURE_CTRL_I[uart_irq_pkg::FEATURE_CONTROL_RS485_BIT];
   // polled mode is fifos on with no low mask bit set; flags still update
   wire polled = fifo_on && (mask_ff[3:0] == 4'h0);

   // event terms
   wire rx_evt = fifo_on ? ENG_I.rx_at_trigger :
      ENG_I.rx_fifo_nonempty;
   wire tx_cond = rs485 ? ENG_I.tx_all_empty :
      (fifo_on ? (ENG_I.tx_below_trigger || ENG_I.tx_all_empty)
               : ENG_I.tx_hold_empty);
   wire line_any = |line_err_ff;
   wire modem_any = |ENG_I.modem_delta;

   // enabled pending sources, lines 1..7
   wire p_line = mask_vis[2] && line_any;
   wire p_tmo = mask_vis[0] && tmo_q;
   wire p_rx = mask_vis[0] && rx_evt;
   wire p_tx = mask_vis[1] && tx_pend_ff;
   wire p_modem = mask_vis[3] && modem_any;
   wire p_xoff = mask_vis[5] && (xoff_ff || special_ff);
   wire p_flow = (mask_vis[6] || mask_vis[7]) && flow_ff;
   wire any_pend = p_line || p_tmo || p_rx || p_tx || p_modem ||
      p_xoff || p_flow;

   // priority encoder, highest first
   wire [5:0] src_code =
      p_line ? uart_irq_pkg::SRC_LINE :
      p_tmo ? uart_irq_pkg::SRC_TIMEOUT :
      p_rx ? uart_irq_pkg::SRC_RXDATA :
      p_tx ? uart_irq_pkg::SRC_TRANSMIT_READY_EVENT :
      p_modem ? uart_irq_pkg::SRC_MODEM :
      p_xoff ? uart_irq_pkg::SRC_XOFF :
      p_flow ? uart_irq_pkg::SRC_FLOW :
      uart_irq_pkg::SRC_NONE;

   wire [7:0] src_rd = {fifo_on, fifo_on, src_code};
   wire [7:0] line_rd = {ENG_I.rx_any_err, ENG_I.tx_all_empty,
      ENG_I.tx_hold_empty, line_err_ff, dready_ff};
   wire [7:0] modem_rd = {4'h0, ENG_I.modem_delta};
   wire [7:0] rd_byte =
      hit_mask ? mask_vis :
      hit_src ? src_rd :
      hit_line ? line_rd :
      hit_modem ? modem_rd :
      hit_efr ? efr_ff :
      hit_fcr ? fcr_ff : 8'h00;

   // timeout counts idle bit times while data sits in the fifo
   uart_rx_timeout tmo_u (
      .clk_i(MCLK_I),
      .rst_i(SYS_RST_I),
      .bit_tick_i(BIT_TICK_I),
      .restart_i(ENG_I.rx_char_in || rd_rx),
      .armed_i(ENG_I.rx_fifo_nonempty && fifo_on),
      .expired_o(tmo_q)
   );

   // bus registers and strobes
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         mask_ff <= uart_irq_pkg::MASK_RESET;
         efr_ff <= 8'h00;
         fcr_ff <= 8'h00;
         ack_ff <= 1'b0;
         rdat_ff <= 32'h0000_0000;
         rxrd_ff <= 1'b0;
         txwr_ff <= 1'b0;
         txd_ff <= 8'h00;
      end else begin
         ack_ff <= req;
         rdat_ff <= rd ? {24'h00_0000, rd_byte} : 32'h0000_0000;
         rxrd_ff <= rd_rx;
         txwr_ff <= wr_tx;
         if (wr_tx) begin
            txd_ff <= WB_DAT_I[7:0];
         end
         if (wr_mask) begin
            mask_ff <= enh ? WB_DAT_I[7:0] :
               {mask_ff[7:4], WB_DAT_I[3:0]};
         end
         if (wr && hit_efr) begin
            efr_ff <= WB_DAT_I[7:0];
         end
         if (wr && hit_fcr) begin
            fcr_ff <= WB_DAT_I[7:0];
         end
      end
   end

   // interrupt flags: set wins over clear in every flag
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         dready_ff <= 1'b0;
         line_err_ff <= 4'h0;
         tx_pend_ff <= 1'b0;
         tx_src_ff <= 1'b0;
         xoff_ff <= 1'b0;
         special_ff <= 1'b0;
         flow_ff <= 1'b0;
      end else begin
         // data ready follows the fifo, set on the arrival itself
         dready_ff <= ENG_I.rx_char_in || ENG_I.rx_fifo_nonempty;
         // errors latch on a received char or an overrun, cleared by line read
         if (ENG_I.rx_char_in || ENG_I.rx_overrun) begin
            line_err_ff <= {ENG_I.rx_head_err, ENG_I.rx_overrun};
         end else if (rd_line) begin
            line_err_ff <= 4'h0;
         end
         // transmit ready: rising condition or enabling while empty
         tx_src_ff <= tx_cond;
         if ((tx_cond && !tx_src_ff) ||
             (wr_mask && WB_DAT_I[1] && !mask_ff[1] && tx_cond)) begin
            tx_pend_ff <= 1'b1;
         end else if ((rd_src && src_code == uart_irq_pkg::SRC_TRANSMIT_READY_EVENT) ||
                      wr_tx || !tx_cond) begin
            tx_pend_ff <= 1'b0;
         end
         if (ENG_I.xoff_seen) begin
            xoff_ff <= 1'b1;
         end else if (rd_src || ENG_I.xon_seen) begin
            xoff_ff <= 1'b0;
         end
         if (ENG_I.special_seen) begin
            special_ff <= 1'b1;
         end else if (rd_src || ENG_I.rx_char_in) begin
            special_ff <= 1'b0;
         end
         if ((mask_vis[6] && ENG_I.rts_rise) ||
             (mask_vis[7] && ENG_I.cts_rise)) begin
            flow_ff <= 1'b1;
         end else if (rd_modem) begin
            flow_ff <= 1'b0;
         end
      end
   end

   // outputs registered; irq follows the encoder one cycle later
   // polled mode quiets only the low sources, enhanced ones still fire
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         irq_ff <= 1'b0;
         sleep_ff <= 1'b0;
      end else begin
         irq_ff <= polled ? (p_xoff || p_flow) : any_pend;
         sleep_ff <= mask_vis[4];
      end
   end

   assign WB_ACK_O = ack_ff;
   assign WB_DAT_O = rdat_ff;
   assign IRQ_O = irq_ff;
   assign SLEEP_EN_O = sleep_ff;
   assign RX_READ_O = rxrd_ff;
   assign TX_WRITE_O = txwr_ff;
   assign TX_DATA_O = txd_ff;
endmodule

// ===== hw/uart_irq_pkg.sv
// constants and carrier types for the channel interrupt logic
package uart_irq_pkg;
   // wishbone word addresses (byte address bits 4:2)
   localparam logic [2:0] ADR_RX_TX = 3'h0;
   localparam logic [2:0] ADR_MASK = 3'h1;
   localparam logic [2:0] ADR_SOURCE = 3'h2;
   localparam logic [2:0] ADR_FCR = 3'h3;
   localparam logic [2:0] ADR_LINE = 3'h5;
   localparam logic [2:0] ADR_MODEM = 3'h6;
   localparam logic [2:0] ADR_EFR = 3'h7;
   // field positions
   localparam int EFR_ENH_BIT = 4;
   localparam int FCR_EN_BIT = 0;
   localparam int FEATURE_CONTROL_RS485_BIT = 3;
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [7:0] LOW_MASK = 8'h0F;
   // source codes, bits 5:0
   localparam logic [5:0] SRC_LINE = 6'h06;
   localparam logic [5:0] SRC_TIMEOUT = 6'h0C;
   localparam logic [5:0] SRC_RXDATA = 6'h04;
   localparam logic [5:0] SRC_TRANSMIT_READY_EVENT = 6'h02;
   localparam logic [5:0] SRC_MODEM = 6'h00;
   localparam logic [5:0] SRC_XOFF = 6'h10;
   localparam logic [5:0] SRC_FLOW = 6'h20;
   localparam logic [5:0] SRC_NONE = 6'h01;
   // receive timeout: 4 characters plus 12 bits, in bit times
   localparam int TMO_CHARS = 4;
   localparam int TMO_BITS = 12;
   localparam int BITS_PER_CHAR = 10;
   localparam logic [7:0] TMO_BIT_TIMES =
      8'(TMO_CHARS * BITS_PER_CHAR + TMO_BITS);
   // status arriving from the serial engine
   typedef struct packed {
      logic rx_fifo_nonempty;
      logic rx_at_trigger;
      logic rx_overrun;
      logic [2:0] rx_head_err;
      logic rx_any_err;
      logic rx_char_in;
      logic tx_hold_empty;
      logic tx_below_trigger;
      logic tx_all_empty;
      logic [3:0] modem_delta;
      logic xoff_seen;
      logic xon_seen;
      logic special_seen;
      logic rts_rise;
      logic cts_rise;
   } engine_s;
endpackage

// ===== hw/uart_rx_timeout.sv
// receive timeout timer counted in bit-time enable pulses
`timescale 1ns/1ns
module uart_rx_timeout (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic bit_tick_i,
   input wire logic restart_i,
   input wire logic armed_i,
   output logic expired_o
);
   logic [7:0] cnt_ff;
   // restarts on every received char or read; stops once expired
   always_ff @(posedge clk_i) begin
      if (rst_i || restart_i || !armed_i) begin
         cnt_ff <= 8'h00;
         expired_o <= 1'b0;
      end else if (bit_tick_i && !expired_o) begin
         cnt_ff <= cnt_ff + 8'h01;
         if (cnt_ff == uart_irq_pkg::TMO_BIT_TIMES - 8'h01) begin
            expired_o <= 1'b1;
         end
      end
   end
endmodule

// ===== dv/uart_channel_interrupt_logic_asserts.sv
// bound checker for the channel interrupt logic ports
`timescale 1ns/1ns
module uart_channel_interrupt_logic_asserts (
   input wire logic MCLK_I,
   input wire logic SYS_RST_I,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [4:2] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic WB_ACK_O,
   input wire uart_irq_pkg::engine_s ENG_I,
   input wire logic IRQ_O,
   input wire logic SLEEP_EN_O,
   input wire logic RX_READ_O,
   input wire logic TX_WRITE_O,
   input wire logic [7:0] TX_DATA_O
);
   default clocking @(posedge MCLK_I); endclocking
   default disable iff (SYS_RST_I);
   // answering-edge decodes; address is still held by the master here
   wire rd_w = WB_ACK_O && !WB_WE_I;
   wire wr_w = WB_ACK_O && WB_WE_I && WB_SEL_I[0];
   wire hold_w = WB_ADR_I == uart_irq_pkg::ADR_RX_TX;
   wire src_w = rd_w && WB_ADR_I == uart_irq_pkg::ADR_SOURCE;
   wire line_w = rd_w && WB_ADR_I == uart_irq_pkg::ADR_LINE;
   wire cfg_w = wr_w && WB_ADR_I inside {3'h1, 3'h7};
   sequence take_s;
      WB_CYC_I && WB_STB_I && !WB_ACK_O;
   endsequence
   sequence answer_s;
      WB_ACK_O ##1 !WB_ACK_O;
   endsequence
   AST_ACK: assert property (take_s |=> answer_s)
      else $error("ack not a single pulse after request");
   AST_DAT: assert property (!rd_w |-> WB_DAT_O == 32'h00000000)
      else $error("read data not zero outside read ack");
   AST_RXRD: assert property (RX_READ_O == (rd_w && hold_w))
      else $error("holding read pulse wrong");
   AST_TXWR: assert property (wr_w && hold_w |-> TX_WRITE_O &&
      TX_DATA_O == WB_DAT_I[7:0]) else $error("holding write pulse missing");
   AST_SLEEP: assert property (!cfg_w |=> $stable(SLEEP_EN_O))
      else $error("sleep enable moved without a write");
   AST_SRC: assert property (src_w |-> WB_DAT_O[7] == WB_DAT_O[6] &&
      WB_DAT_O[5:0] inside {6'h06, 6'h0C, 6'h04, 6'h02, 6'h00, 6'h10,
      6'h20, 6'h01}) else $error("source read not a legal code");
   // status byte is registered at the taking edge
   AST_LINE: assert property (line_w |->
      {WB_DAT_O[7:2], WB_DAT_O[0]} == $past({ENG_I.rx_any_err,
      ENG_I.tx_all_empty, ENG_I.tx_hold_empty, ENG_I.rx_head_err,
      ENG_I.rx_fifo_nonempty})) else $error("line status bits wrong");
   AST_IRQ: assert property (src_w && WB_DAT_O[5:0] == 6'h01
      |-> !IRQ_O) else $error("interrupt active with nothing pending");
endmodule

// ===== dv/uart_engine_model.sv
// serial engine stand-in feeding status to the interrupt logic
`timescale 1ns/1ns
module uart_engine_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic push_i,
   input wire logic [2:0] err_i,
   input wire logic rx_read_i,
   input wire logic tx_write_i,
   input wire logic xoff_i,
   input wire logic [3:0] delta_i,
   input wire logic ovr_i,
   input wire logic [1:0] flow_i,
   output uart_irq_pkg::engine_s eng_o
);
   logic [6:0] fill_ff;
   logic [2:0] err_ff;
   logic hold_ff;
   wire pop = rx_read_i && fill_ff != 7'h00;
   // reading an empty fifo leaves the count alone
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fill_ff <= 7'h00;
         err_ff <= 3'h0;
         hold_ff <= 1'b1;
      end else begin
         fill_ff <= fill_ff + 7'(push_i) - 7'(pop);
         err_ff <= push_i ? err_i : (pop ? 3'h0 : err_ff);
         hold_ff <= hold_ff && !tx_write_i;
      end
   end
   // head error shown with the arrival pulse, trigger level of one
   always_comb begin
      eng_o = '0;
      eng_o.rx_fifo_nonempty = fill_ff != 7'h00;
      eng_o.rx_at_trigger = fill_ff != 7'h00;
      eng_o.rx_head_err = push_i ? err_i : err_ff;
      eng_o.rx_any_err = eng_o.rx_head_err != 3'h0;
      eng_o.rx_char_in = push_i;
      eng_o.tx_hold_empty = hold_ff;
      eng_o.tx_below_trigger = hold_ff;
      eng_o.tx_all_empty = hold_ff;
      eng_o.modem_delta = delta_i;
      eng_o.xoff_seen = xoff_i;
      eng_o.rx_overrun = ovr_i;
      eng_o.rts_rise = flow_i[0];
      eng_o.cts_rise = flow_i[1];
   end
endmodule

// ===== dv/tb_uart_channel_interrupt_logic.sv
// self-checking bench for the channel interrupt logic
`timescale 1ns/1ns
module tb_uart_channel_interrupt_logic;
   logic MCLK_I = 1'b0, SYS_RST_I = 1'b1, cyc = 1'b0, we = 1'b0;
   logic tick = 1'b0, push = 1'b0, xoff = 1'b0, ovr = 1'b0;
   logic [1:0] flow = 2'h0;
   logic [2:0] adr = 3'h0, err = 3'h0;
   logic [3:0] delta = 4'h0;
   logic [7:0] wdat = 8'h00, rd, tx_dat;
   logic [31:0] rdat;
   logic ack, irq, sleep, rx_rd, tx_wr;
   uart_irq_pkg::engine_s eng;
   int n_errors = 0, n_compared = 0;
   // top nibble {write, address}, then write data, then value read back
   localparam logic [19:0] ROWS [9] = '{20'h10000, 20'h20001, 20'h9FF00,
      20'h1000F, 20'hF1000, 20'h70010, 20'h9F000, 20'h100F0, 20'h40000};
   always #5 MCLK_I = ~MCLK_I;
   uart_channel_interrupt_logic uut (.MCLK_I(MCLK_I), .SYS_RST_I(SYS_RST_I),
      .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(we), .WB_ADR_I(adr),
      .WB_SEL_I(4'hF), .WB_DAT_I({24'h000000, wdat}), .WB_DAT_O(rdat),
      .WB_ACK_O(ack), .ENG_I(eng), .BIT_TICK_I(tick), .FEATURE_CTRL_I(8'h00),
      .IRQ_O(irq), .SLEEP_EN_O(sleep), .RX_READ_O(rx_rd), .TX_WRITE_O(tx_wr),
      .TX_DATA_O(tx_dat));
   uart_engine_model eng_model (.clk_i(MCLK_I), .rst_i(SYS_RST_I),
      .push_i(push), .err_i(err), .rx_read_i(rx_rd), .tx_write_i(tx_wr),
      .xoff_i(xoff), .delta_i(delta), .ovr_i(ovr), .flow_i(flow),
      .eng_o(eng));
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e,
      input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one classic cycle; ack and data are sampled at the same edge
   task automatic wb(input logic w, input logic [2:0] a, input logic [7:0] d);
      int i = 0;
      @(posedge MCLK_I);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge MCLK_I);
         i++;
      end while (ack !== 1'b1 && i < 20);
      rd = rdat[7:0];
      cyc <= 1'b0;
      if (ack !== 1'b1) begin
         n_errors++;
         conclude();
      end
   endtask
   task automatic rchk(input string nm, input logic [2:0] a,
      input logic [7:0] e);
      wb(1'b0, a, 8'h00);
      chk(nm, e, rd);
   endtask
   // one received character, or one pause character when x is set
   task automatic strobe(input logic x, input logic [2:0] e);
      @(posedge MCLK_I);
      push <= !x;
      xoff <= x;
      err <= e;
      @(posedge MCLK_I);
      push <= 1'b0;
      xoff <= 1'b0;
   endtask
   initial begin
      repeat (2) @(posedge MCLK_I);
      SYS_RST_I <= 1'b0;
      for (int k = 0; k < 9; k++) begin
         wb(ROWS[k][19], ROWS[k][18:16], ROWS[k][15:8]);
         if (!ROWS[k][19]) chk("row", ROWS[k][7:0], rd);
      end
      chk("sleep", 8'h01, {7'h00, sleep});
      wb(1'b1, uart_irq_pkg::ADR_EFR, 8'h00);
      rchk("mask", uart_irq_pkg::ADR_MASK, 8'h00);
      $display("register rows done");
      wb(1'b1, uart_irq_pkg::ADR_FCR, 8'h01);
      wb(1'b1, uart_irq_pkg::ADR_MASK, 8'h0F);
      rchk("src tx", uart_irq_pkg::ADR_SOURCE, 8'hC2);
      chk("irq", 8'h01, {7'h00, irq});
      wb(1'b1, uart_irq_pkg::ADR_RX_TX, 8'h5A);
      strobe(1'b0, 3'h2);
      rchk("src line", uart_irq_pkg::ADR_SOURCE, 8'hC6);
      rchk("line", uart_irq_pkg::ADR_LINE, 8'h89);
      rchk("src rx", uart_irq_pkg::ADR_SOURCE, 8'hC4);
      wb(1'b0, uart_irq_pkg::ADR_RX_TX, 8'h00);
      rchk("src none", uart_irq_pkg::ADR_SOURCE, 8'hC1);
      chk("irq", 8'h00, {7'h00, irq});
      $display("priority test done");
      wb(1'b1, uart_irq_pkg::ADR_MASK, 8'h01);
      strobe(1'b0, 3'h0);
      repeat (uart_irq_pkg::TMO_BIT_TIMES - 8'h01) @(posedge MCLK_I) tick <= 1'b1;
      @(posedge MCLK_I) tick <= 1'b0;
      rchk("src early", uart_irq_pkg::ADR_SOURCE, 8'hC4);
      // the last bit time of the window must fire the timeout
      @(posedge MCLK_I) tick <= 1'b1;
      @(posedge MCLK_I) tick <= 1'b0;
      rchk("src tmo", uart_irq_pkg::ADR_SOURCE, 8'hCC);
      wb(1'b0, uart_irq_pkg::ADR_RX_TX, 8'h00);
      rchk("src tmo clr", uart_irq_pkg::ADR_SOURCE, 8'hC1);
      $display("timeout test done");
      wb(1'b1, uart_irq_pkg::ADR_EFR, 8'h10);
      wb(1'b1, uart_irq_pkg::ADR_MASK, 8'h20);
      strobe(1'b1, 3'h0);
      repeat (2) @(posedge MCLK_I);
      chk("irq pause", 8'h01, {7'h00, irq});
      rchk("src pause", uart_irq_pkg::ADR_SOURCE, 8'hD0);
      rchk("src pause clr", uart_irq_pkg::ADR_SOURCE, 8'hC1);
      chk("irq pause clr", 8'h00, {7'h00, irq});
      wb(1'b1, uart_irq_pkg::ADR_MASK, 8'h08);
      @(posedge MCLK_I) delta <= 4'h1;
      rchk("src modem", uart_irq_pkg::ADR_SOURCE, 8'hC0);
      rchk("modem", uart_irq_pkg::ADR_MODEM, 8'h01);
      @(posedge MCLK_I) delta <= 4'h0;
      // flow pin rises, each seen only through its own mask bit
      wb(1'b1, uart_irq_pkg::ADR_MASK, 8'h80);
      @(posedge MCLK_I) flow <= 2'h2;
      @(posedge MCLK_I) flow <= 2'h0;
      rchk("src cts", uart_irq_pkg::ADR_SOURCE, 8'hE0);
      rchk("modem cts", uart_irq_pkg::ADR_MODEM, 8'h00);
      rchk("src flow clr", uart_irq_pkg::ADR_SOURCE, 8'hC1);
      wb(1'b1, uart_irq_pkg::ADR_MASK, 8'h40);
      @(posedge MCLK_I) flow <= 2'h1;
      @(posedge MCLK_I) flow <= 2'h0;
      rchk("src rts", uart_irq_pkg::ADR_SOURCE, 8'hE0);
      rchk("modem rts", uart_irq_pkg::ADR_MODEM, 8'h00);
      $display("event test done");
      wb(1'b1, uart_irq_pkg::ADR_MASK, 8'h00);
      strobe(1'b0, 3'h0);
      rchk("line polled", uart_irq_pkg::ADR_LINE, 8'h01);
      chk("irq polled", 8'h00, {7'h00, irq});
      @(posedge MCLK_I) ovr <= 1'b1;
      @(posedge MCLK_I) ovr <= 1'b0;
      rchk("line ovr", uart_irq_pkg::ADR_LINE, 8'h03);
      // give reset something to undo: mask and sleep both set
      wb(1'b1, uart_irq_pkg::ADR_MASK, 8'h10);
      rchk("mask sleep", uart_irq_pkg::ADR_MASK, 8'h10);
      chk("sleep on", 8'h01, {7'h00, sleep});
      @(posedge MCLK_I) SYS_RST_I <= 1'b1;
      repeat (2) @(posedge MCLK_I);
      SYS_RST_I <= 1'b0;
      rchk("mask reset", uart_irq_pkg::ADR_MASK, 8'h00);
      chk("sleep reset", 8'h00, {7'h00, sleep});
      $display("polled and reset test done");
      conclude();
   end
endmodule
bind uart_channel_interrupt_logic uart_channel_interrupt_logic_asserts u_chk (
   .MCLK_I(MCLK_I),
   .SYS_RST_I(SYS_RST_I),
   .WB_CYC_I(WB_CYC_I),
   .WB_STB_I(WB_STB_I),
   .WB_WE_I(WB_WE_I),
   .WB_ADR_I(WB_ADR_I),
   .WB_SEL_I(WB_SEL_I),
   .WB_DAT_I(WB_DAT_I),
   .WB_DAT_O(WB_DAT_O),
   .WB_ACK_O(WB_ACK_O),
   .ENG_I(ENG_I),
   .IRQ_O(IRQ_O),
   .SLEEP_EN_O(SLEEP_EN_O),
   .RX_READ_O(RX_READ_O),
   .TX_WRITE_O(TX_WRITE_O),
   .TX_DATA_O(TX_DATA_O)
);
